// ==== sirr_pkg.sv ====
// shared constants and types for the serial request router
package sirr_pkg;

   // channel counts
   localparam int NCH = 6; // serial channels handled
   localparam int NDMACH = 4; // channels with dma requests
   localparam int DMA_W = 10; // dma controller request inputs 0..9

   // printed register offsets are word indices; byte address = index * 4
   localparam logic [31:0] IDX_STAT23 = 32'h0080_0100; // group 2/3 status
   localparam logic [31:0] IDX_MASK_LO = 32'h0080_0101; // mask channels 0..3
   localparam logic [31:0] IDX_SEL_LO = 32'h0080_0102; // cause select 0..3
   localparam logic [31:0] IDX_STAT45 = 32'h0080_0a00; // group 4/5 status
   localparam logic [31:0] IDX_MASK_HI = 32'h0080_0a01; // mask channels 4..5
   localparam logic [31:0] IDX_SEL_HI = 32'h0080_0a02; // cause select 4..5
   localparam int ADDR_SHIFT = 2; // index to byte address
   localparam logic [31:0] ADDR_STAT23 = IDX_STAT23 << ADDR_SHIFT;
   localparam logic [31:0] ADDR_MASK_LO = IDX_MASK_LO << ADDR_SHIFT;
   localparam logic [31:0] ADDR_SEL_LO = IDX_SEL_LO << ADDR_SHIFT;
   localparam logic [31:0] ADDR_STAT45 = IDX_STAT45 << ADDR_SHIFT;
   localparam logic [31:0] ADDR_MASK_HI = IDX_MASK_HI << ADDR_SHIFT;
   localparam logic [31:0] ADDR_SEL_HI = IDX_SEL_HI << ADDR_SHIFT;

   // field layout: request vector bit 2c is transmit, 2c+1 is receive of channel c
   localparam int REQ_W = 2 * NCH; // 12 request bits
   localparam int STAT23_LSB = 4; // group 2/3 bits sit at 7:4
   localparam int STAT45_LSB = 0; // group 4/5 bits sit at 3:0
   localparam int GRP23_BASE = 4; // request vector index of channel 2 tx
   localparam int GRP45_BASE = 8; // request vector index of channel 4 tx
   localparam int GRP_W = 4; // bits per group
   localparam int SEL_LO_W = 4; // cause select bits for channels 0..3
   localparam int SEL_HI_W = 2; // cause select bits for channels 4..5
   localparam logic [7:0] REG_RESET = 8'h00; // reset of every register

   // fixed dma controller input for the transmit and receive of channels 0..3
   localparam int DMA_TX_MAP [NDMACH] = '{3, 6, 7, 9};
   localparam int DMA_RX_MAP [NDMACH] = '{4, 3, 5, 8};

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // per-channel condition inputs from the serial channel cores
   typedef struct packed {
      logic txEmpty; // transmit buffer holds no data
      logic rxComplete; // receive complete flag (buffer full)
      logic rxError; // receive error summary
      logic txEnable; // transmit enable bit
      logic rxEnable; // receive enable bit
   } sirr_chan_s;

   // dedicated interrupt lines of channels 0 and 1
   typedef struct packed {
      logic tx0; // channel 0 transmit
      logic rx0; // channel 0 receive
      logic tx1; // channel 1 transmit
      logic rx1; // channel 1 receive
   } sirr_dedirq_s;

endpackage

// ==== sirr_router.sv ====
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// (R1) transmit request while transmit buffer empty
// (R2) receive request cause: finished or error, selectable
// (R3) requests leave only if enabled and unmasked
// (R4) channels 2/3 and 4/5 share group lines
// (R5) channels 0,1 have dedicated tx, rx lines
// (R6) enabling transmit with mask set interrupts immediately
// (R7) dma requests only while enable bit set
// (R8) software sets dma controller before enabling channel
// (R9) receive error suppresses receive dma request
// (R10) transmit dma when buffer empty and enabled
// (R11) receive dma when receive complete flag rises
// (R12) dma requests go to fixed controller inputs
// (R13) external clocked_serial_mode clock at most one sixteenth
// (R14) status bits set by hardware only
// (R15) write zero clears; hardware set wins
// (R16) mask one enables, zero blocks request
// (R17) group line is OR of masked status
module sirr_router
   import sirr_pkg::*;
(
   input wire logic clk, // 200 mhz clock
   input wire logic rst, // synchronous reset, active high
   input wire logic ce, // clock enable, freezes all state when low
   input wire sirr_chan_s [NCH-1:0] chanIn, // per-channel conditions
   output sirr_dedirq_s dedIrq_q, // dedicated lines of channels 0,1
   output logic irqGrp23_q, // group line of channels 2,3
   output logic irqGrp45_q, // group line of channels 4,5
   output logic irq_q, // summary interrupt, any line active
   output logic [DMA_W-1:0] dmaReq_q, // dma controller request inputs
   input wire logic [31:0] awaddr, // write address
   input wire logic [2:0] awprot, // write protection, ignored
   input wire logic awvalid, // write address valid
   output logic awready_q, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // write strobes
   input wire logic wvalid, // write data valid
   output logic wready_q, // write data ready
   output logic [1:0] bresp_q, // write response
   output logic bvalid_q, // write response valid
   input wire logic bready, // write response ready
   input wire logic [31:0] araddr, // read address
   input wire logic [2:0] arprot, // read protection, ignored
   input wire logic arvalid, // read address valid
   output logic arready_q, // read address ready
   output logic [31:0] rdata_q, // read data
   output logic [1:0] rresp_q, // read response
   output logic rvalid_q, // read data valid
   input wire logic rready // read data ready
);

   // software registers
   logic [7:0] maskLo_q; // mask channels 0..3
   logic [7:0] maskHi_q; // mask channels 4..5 in bits 3:0
   logic [SEL_LO_W-1:0] selLo_q; // cause select channels 0..3
   logic [SEL_HI_W-1:0] selHi_q; // cause select channels 4..5
   logic [GRP_W-1:0] stat23_q; // sticky status channels 2,3
   logic [GRP_W-1:0] stat45_q; // sticky status channels 4,5
   logic [GRP_W-1:0] stat23_d; // next status channels 2,3
   logic [GRP_W-1:0] stat45_d; // next status channels 4,5
   logic [NCH-1:0] rxDonePrev_q; // previous receive complete flags

   // write channel holding registers
   logic [31:0] awAddr_q; // captured write address
   logic awFull_q; // write address held
   logic [31:0] wData_q; // captured write data
   logic wLane0_q; // low byte lane strobed
   logic wFull_q; // write data held

   // derived request terms
   logic [REQ_W-1:0] req; // raw requests, bit 2c tx, 2c+1 rx
   logic [REQ_W-1:0] maskAll; // masks in request layout
   logic [NCH-1:0] selAll; // cause select per channel
   logic [DMA_W-1:0] dmaNext; // next dma request vector
   logic [NDMACH-1:0] dmaTx; // transmit dma per channel
   logic [NDMACH-1:0] dmaRx; // receive dma per channel

   assign maskAll = {maskHi_q[GRP_W-1:0], maskLo_q};
   assign selAll = {selHi_q, selLo_q};

   // per-channel request generation
   genvar c;
   generate
      for (c = 0; c < NCH; c++)
      begin : gChan
         wire rxCause;
         // receive cause: error when select bit is one, else finished
         assign rxCause = selAll[c] ? chanIn[c].rxError : chanIn[c].rxComplete; // R2
         // transmit request follows empty buffer while enabled, so it fires on enable
         assign req[2*c] = chanIn[c].txEmpty & chanIn[c].txEnable; // R1 R6 R3
         assign req[2*c+1] = rxCause & chanIn[c].rxEnable; // R3
      end
      for (c = 0; c < NDMACH; c++)
      begin : gDma
         // transmit dma: buffer empty and transmit enabled
         assign dmaTx[c] = chanIn[c].txEmpty & chanIn[c].txEnable; // R10 R7
         // receive dma: rising complete flag without error, while enabled
         assign dmaRx[c] = chanIn[c].rxComplete & ~rxDonePrev_q[c]
                           & ~chanIn[c].rxError & chanIn[c].rxEnable; // R11 R9 R7
      end
   endgenerate

   // route dma requests onto fixed controller inputs, sharing where they coincide
   always_comb
   begin
      dmaNext = '0;
      for (int k = 0; k < NDMACH; k++)
      begin
         dmaNext[DMA_TX_MAP[k]] = dmaNext[DMA_TX_MAP[k]] | dmaTx[k]; // R12
         dmaNext[DMA_RX_MAP[k]] = dmaNext[DMA_RX_MAP[k]] | dmaRx[k]; // R12
      end
   end

   // write decode
   wire wrFire = awFull_q & wFull_q & ~bvalid_q; // both halves held, response free
   wire wrLane = wrFire & wLane0_q; // low byte actually written
   wire hitStat23 = awAddr_q == ADDR_STAT23; // group 2/3 status
   wire hitStat45 = awAddr_q == ADDR_STAT45; // group 4/5 status
   wire hitMaskLo = awAddr_q == ADDR_MASK_LO; // mask low
   wire hitMaskHi = awAddr_q == ADDR_MASK_HI; // mask high
   wire hitSelLo = awAddr_q == ADDR_SEL_LO; // cause select low
   wire hitSelHi = awAddr_q == ADDR_SEL_HI; // cause select high
   wire wrMapped = hitStat23 | hitStat45 | hitMaskLo | hitMaskHi | hitSelLo | hitSelHi;

   // status clear: only bits written as zero clear, ones keep the old value
   wire [GRP_W-1:0] clr23 = (wrLane & hitStat23)
                            ? ~wData_q[STAT23_LSB +: GRP_W] : '0; // R14 R15
   wire [GRP_W-1:0] clr45 = (wrLane & hitStat45)
                            ? ~wData_q[STAT45_LSB +: GRP_W] : '0; // R14 R15

   // hardware set is or-ed after the clear, so a coincident set wins
   assign stat23_d = (stat23_q & ~clr23) | req[GRP23_BASE +: GRP_W]; // R15
   assign stat45_d = (stat45_q & ~clr45) | req[GRP45_BASE +: GRP_W]; // R15

   // read decode
   wire rdStat23 = araddr == ADDR_STAT23; // group 2/3 status
   wire rdStat45 = araddr == ADDR_STAT45; // group 4/5 status
   wire rdMaskLo = araddr == ADDR_MASK_LO; // mask low
   wire rdMaskHi = araddr == ADDR_MASK_HI; // mask high
   wire rdSelLo = araddr == ADDR_SEL_LO; // cause select low
   wire rdSelHi = araddr == ADDR_SEL_HI; // cause select high
   wire rdMapped = rdStat23 | rdStat45 | rdMaskLo | rdMaskHi | rdSelLo | rdSelHi;
   wire [7:0] st23Byte = {stat23_q, {STAT23_LSB{1'b0}}}; // unused low bits read 0
   wire [7:0] st45Byte = {{(8-GRP_W){1'b0}}, stat45_q}; // unused high bits read 0
   wire [7:0] rdByte = rdStat23 ? st23Byte
                     : rdStat45 ? st45Byte
                     : rdMaskLo ? maskLo_q
                     : rdMaskHi ? maskHi_q
                     : rdSelLo ? {{(8-SEL_LO_W){1'b0}}, selLo_q}
                     : rdSelHi ? {{(8-SEL_HI_W){1'b0}}, selHi_q}
                     : 8'h00;

   // masked request lines
   wire [REQ_W-1:0] reqMasked = req & maskAll; // R16 R3
   wire grp23 = |(stat23_q & maskAll[GRP23_BASE +: GRP_W]); // R17 R4 R16
   wire grp45 = |(stat45_q & maskAll[GRP45_BASE +: GRP_W]); // R17 R4 R16

   // channel positions of the two channels with dedicated lines
   localparam int CH0 = 0; // first dedicated channel
   localparam int CH1 = 1; // second dedicated channel

   // bus handshake terms
   wire awTake = awvalid & awready_q; // write address taken this cycle
   wire wTake = wvalid & wready_q; // write data taken this cycle
   wire bDone = bvalid_q & bready; // write response accepted
   wire arTake = arvalid & arready_q; // read address taken this cycle
   wire rDone = rvalid_q & rready; // read data accepted

   // a holding slot fills when taken and empties when its write fires
   wire awFull_d = (awFull_q & ~wrFire) | awTake; // next write address held
   wire wFull_d = (wFull_q & ~wrFire) | wTake; // next write data held

   // responses stand until the master takes them
   wire bvalid_d = (bvalid_q & ~bDone) | wrFire; // next write response valid
   wire rvalid_d = (rvalid_q & ~rDone) | arTake; // next read data valid
   wire [1:0] wrResp = wrMapped ? RESP_OKAY : RESP_SLVERR; // unmapped write errors
   wire [1:0] rdResp = rdMapped ? RESP_OKAY : RESP_SLVERR; // unmapped read errors
   wire [31:0] rdWord = 32'(rdByte); // register byte in the low lane

   // software register next values, written only through the low lane
   wire [7:0] maskLo_d = (wrLane & hitMaskLo) ? wData_q[7:0] : maskLo_q; // R16
   wire [7:0] maskHi_d = (wrLane & hitMaskHi)
                         ? {{(8-GRP_W){1'b0}}, wData_q[GRP_W-1:0]} : maskHi_q; // R16
   wire [SEL_LO_W-1:0] selLo_d = (wrLane & hitSelLo)
                                 ? wData_q[SEL_LO_W-1:0] : selLo_q; // R2
   wire [SEL_HI_W-1:0] selHi_d = (wrLane & hitSelHi)
                                 ? wData_q[SEL_HI_W-1:0] : selHi_q; // R2

   // dedicated lines follow the masked requests of channels 0 and 1
   sirr_dedirq_s dedNext; // next dedicated line values
   assign dedNext.tx0 = reqMasked[2*CH0]; // R5
   assign dedNext.rx0 = reqMasked[2*CH0+1]; // R5
   assign dedNext.tx1 = reqMasked[2*CH1]; // R5
   assign dedNext.rx1 = reqMasked[2*CH1+1]; // R5

   // summary line: any dedicated or group line active
   wire irqAny = (|dedNext) | grp23 | grp45; // summary request

   // current receive complete flags, kept for edge detection
   logic [NCH-1:0] rxDoneNow; // receive complete flag per channel

   // gather the receive complete flags into one vector
   always_comb
   begin
      rxDoneNow = '0;
      for (int k = 0; k < NCH; k++)
      begin
         rxDoneNow[k] = chanIn[k].rxComplete; // flag of channel k
      end
   end

   // write address slot: ready while the slot is free
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         awFull_q <= 1'b0;
         awready_q <= 1'b0;
         awAddr_q <= '0;
      end
      else if (ce)
      begin
         awFull_q <= awFull_d;
         awready_q <= ~awFull_d;
         if (awTake)
         begin
            awAddr_q <= awaddr; // capture the address
         end
      end
   end

   // write data slot: ready while the slot is free
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wFull_q <= 1'b0;
         wready_q <= 1'b0;
         wData_q <= '0;
         wLane0_q <= 1'b0;
      end
      else if (ce)
      begin
         wFull_q <= wFull_d;
         wready_q <= ~wFull_d;
         if (wTake)
         begin
            wData_q <= wdata; // capture the data word
            wLane0_q <= wstrb[0]; // low lane carries the register byte
         end
      end
   end

   // write response: raised when both halves meet, held until taken
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else if (ce)
      begin
         bvalid_q <= bvalid_d;
         if (wrFire)
         begin
            bresp_q <= wrResp; // response of the write that fired
         end
      end
   end

   // software registers: masks and cause selects
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         maskLo_q <= REG_RESET;
         maskHi_q <= REG_RESET;
         selLo_q <= REG_RESET[SEL_LO_W-1:0];
         selHi_q <= REG_RESET[SEL_HI_W-1:0];
      end
      else if (ce)
      begin
         maskLo_q <= maskLo_d;
         maskHi_q <= maskHi_d;
         selLo_q <= selLo_d;
         selHi_q <= selHi_d;
      end
   end

   // sticky group status: set by hardware, cleared by a written zero
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stat23_q <= REG_RESET[GRP_W-1:0];
         stat45_q <= REG_RESET[GRP_W-1:0];
      end
      else if (ce)
      begin
         stat23_q <= stat23_d; // R14 R15
         stat45_q <= stat45_d; // R14 R15
      end
   end

   // read channel: one read at a time, data stands until taken
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end
      else if (ce)
      begin
         arready_q <= ~rvalid_d;
         rvalid_q <= rvalid_d;
         if (arTake)
         begin
            rdata_q <= rdWord; // address still stands at the taking edge
            rresp_q <= rdResp; // error for an unmapped address
         end
      end
   end

   // request outputs, all straight from flip-flops
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dedIrq_q <= '0;
         irqGrp23_q <= 1'b0;
         irqGrp45_q <= 1'b0;
         irq_q <= 1'b0;
         dmaReq_q <= '0;
         rxDonePrev_q <= '0;
      end
      else if (ce)
      begin
         dedIrq_q <= dedNext; // R5
         irqGrp23_q <= grp23; // R4 R17
         irqGrp45_q <= grp45; // R4 R17
         irq_q <= irqAny; // summary
         dmaReq_q <= dmaNext; // R12
         rxDonePrev_q <= rxDoneNow; // R11
      end
   end
endmodule

// ==== sirr_router_chk.sv ====
`timescale 1ns/1ps
module sirr_router_chk
   import sirr_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire sirr_chan_s [NCH-1:0] chanIn, // conditions
   input wire sirr_dedirq_s dedIrq_q, // dedicated lines
   input wire logic irqGrp23_q, // group 2/3 line
   input wire logic [DMA_W-1:0] dmaReq_q, // dma lines
   input wire logic awvalid, // write address valid
   input wire logic wvalid, // write data valid
   input wire logic bvalid_q // write response valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // three steady cycles leave the request path room to follow its cause
   property p_txDma; (chanIn[2].txEmpty && chanIn[2].txEnable) [*3] |-> dmaReq_q[7]; endproperty
   a_txDma: assert property (p_txDma) else $error("tx dma low");
   property p_txFull; !chanIn[2].txEmpty [*3] |-> !dmaReq_q[7]; endproperty
   a_txFull: assert property (p_txFull) else $error("tx dma while full");
   property p_dmaOff; !chanIn[3].txEnable [*3] |-> !dmaReq_q[9]; endproperty
   a_dmaOff: assert property (p_dmaOff) else $error("dma while disabled");
   property p_rxErr; chanIn[2].rxError [*3] |-> !dmaReq_q[5]; endproperty
   a_rxErr: assert property (p_rxErr) else $error("rx dma on error");
   property p_rxDma0; $rose(chanIn[0].rxComplete) && chanIn[0].rxEnable
      && !chanIn[0].rxError |-> ##[0:3] dmaReq_q[4]; endproperty
   a_rxDma0: assert property (p_rxDma0) else $error("rx dma 4 missing");
   property p_rxDma3; $rose(chanIn[3].rxComplete) && chanIn[3].rxEnable
      && !chanIn[3].rxError |-> ##[0:3] dmaReq_q[8]; endproperty
   a_rxDma3: assert property (p_rxDma3) else $error("rx dma 8 missing");
   property p_txGate; !chanIn[1].txEnable [*3] |-> !dedIrq_q.tx1; endproperty
   a_txGate: assert property (p_txGate) else $error("tx line while disabled");
   // only a bus write may take a set group request away
   property p_sticky; irqGrp23_q && !awvalid && !wvalid && !bvalid_q |=> irqGrp23_q; endproperty
   a_sticky: assert property (p_sticky) else $error("group line dropped");
endmodule
bind sirr_router sirr_router_chk i_chk (.clk, .rst, .chanIn, .dedIrq_q, .irqGrp23_q,
   .dmaReq_q, .awvalid, .wvalid, .bvalid_q);

// ==== sirr_ctrl_model.sv ====
`timescale 1ns/1ps
module sirr_ctrl_model
   import sirr_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire logic armed, // dma channels set up
   input wire logic [DMA_W-1:0] dmaReq, // request inputs
   output logic [DMA_W-1:0] dmaSeen_q, // inputs raised so far
   output logic misuse_q // request before set-up
);
   // a request before set-up would start a stray transfer
   always_ff @(posedge clk)
   begin
      dmaSeen_q <= rst ? '0 : dmaSeen_q | dmaReq;
      misuse_q <= !rst && (misuse_q || (!armed && |dmaReq));
   end
endmodule

// ==== sirr_router_tb_top.sv ====
`timescale 1ns/1ps
module sirr_router_tb_top import sirr_pkg::*;;
   logic clk = 1'h0, rst = 1'h1, armed = 1'h0; // clock, reset, dma set up
   sirr_chan_s [NCH-1:0] chanIn = '0; // channel conditions
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata_q, d; // bus words
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irqGrp23_q, irq_q, misuse;
   logic irqGrp45_q; // group line of channels 4,5
   logic [1:0] bresp_q, rresp_q, r; // responses
   sirr_dedirq_s dedIrq_q; // dedicated lines
   logic [DMA_W-1:0] dmaReq_q, dmaSeen; // dma lines
   int n_errors = 0, checks = 0; // counters
   always #2.5 clk = !clk;
   sirr_router i_dut (.clk, .rst, .ce(1'h1), .chanIn, .dedIrq_q, .irqGrp23_q, .irqGrp45_q,
      .irq_q, .dmaReq_q, .awaddr, .awprot(3'h0), .awvalid, .awready_q, .wdata, .wstrb(4'hf),
      .wvalid, .wready_q, .bresp_q, .bvalid_q, .bready, .araddr, .arprot(3'h0), .arvalid,
      .arready_q, .rdata_q, .rresp_q, .rvalid_q, .rready);
   sirr_ctrl_model i_ctl (.clk, .rst, .armed, .dmaReq(dmaReq_q), .dmaSeen_q(dmaSeen),
      .misuse_q(misuse));
   // one bus access; each channel released once taken
   task automatic axi(input logic wr, input logic [31:0] a, input logic [7:0] v);
      logic done;
      @(posedge clk);
      {awaddr, araddr, wdata} <= {a, a, 24'h0, v};
      {awvalid, wvalid, bready, arvalid, rready} <= {wr, wr, wr, !wr, !wr};
      done = 1'h0;
      while (!done)
      begin
         @(posedge clk);
         if (awready_q)
            awvalid <= 1'h0;
         if (wready_q)
            wvalid <= 1'h0;
         if (arready_q)
            arvalid <= 1'h0;
         d = rdata_q;
         r = rresp_q;
         done = wr ? bvalid_q : rvalid_q;
      end
      bready <= 1'h0;
      rready <= 1'h0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic test_done();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // main sequence
   initial
   begin
      for (int c = 0; c < NDMACH; c++) chanIn[c].txEmpty = 1'h1;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      axi(1'h0, ADDR_MASK_LO, 8'h0);
      chk("maskLo", {24'h0, REG_RESET}, d);
      axi(1'h0, 32'h40, 8'h0);
      chk("badResp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi(1'h1, ADDR_MASK_LO, 8'h51);
      armed <= 1'h1;
      for (int c = 0; c < NDMACH; c++) chanIn[c].txEnable <= 1'h1;
      repeat (4) @(negedge clk);
      chk("txLines", 32'h2, {30'h0, dedIrq_q.tx0, dedIrq_q.tx1});
      chk("grpLines", 32'h3, {30'h0, irqGrp23_q, irq_q});
      axi(1'h0, ADDR_STAT23, 8'h0);
      chk("stat23", 32'h50, d);
      {chanIn[2].txEmpty, chanIn[3].txEmpty} <= 2'h0;
      axi(1'h1, ADDR_STAT23, 8'hef);
      axi(1'h0, ADDR_STAT23, 8'h0);
      chk("stat23Clr", 32'h40, d);
      chanIn[2].rxError <= 1'h1;
      for (int c = 0; c < NDMACH; c++) chanIn[c].rxEnable <= 1'h1;
      // condition changes spaced as closely as an outside serial clock allows
      repeat (16) @(posedge clk);
      for (int c = 0; c < NDMACH; c++) chanIn[c].rxComplete <= 1'h1;
      repeat (4) @(negedge clk);
      chk("dmaSeen", 32'h3d8, {22'h0, dmaSeen});
      chk("dmaEarly", 32'h0, {31'h0, misuse});
      axi(1'h1, ADDR_MASK_HI, 8'hf1);
      axi(1'h0, ADDR_MASK_HI, 8'h0);
      chk("maskHi", 32'h1, d);
      chanIn[4].txEmpty <= 1'h1;
      chanIn[4].txEnable <= 1'h1;
      repeat (4) @(negedge clk);
      chk("grp45", 32'h1, {31'h0, irqGrp45_q});
      axi(1'h0, ADDR_STAT45, 8'h0);
      chk("stat45", 32'h1, d);
      test_done();
   end
   // hang guard
   initial
   begin
      #100000;
      n_errors++;
      test_done();
   end
endmodule
